/* rtl/iofs_ctrl.sv */
`timescale 1ns/1ps
`include "iofs_regs.svh"
// Overview of operation
// RQ1: out-of-range parameter writes dropped, error flagged
// RQ2: capability flags advertise input/output synchronisation
// RQ3: all channels handled at one common instant
// RQ4: report repeat, processing and lead times
// RQ5: coupler reads timing, writes sync instant
// RQ6: non-sync operation passes data at once
// RQ7: sync mode can be switched off
// RQ8: switch-on values until first valid data
// RQ9: failsafe armed after first valid exchange
// RQ10: missing valid data enters failsafe when armed
// RQ11: 16-bit behaviour code selects failsafe
// RQ12: codes zero, final value, hold last
// RQ13: code three drives substitute values
// RQ14: coupler aligns local cycle with network
// RQ15: substitute object readable, writable, pd length
// RQ16: valid data again resumes normal output
module iofs_ctrl #(
	parameter int PD_W = 16,
	parameter bit IN_SYNC_CAP = 1'b1,
	parameter bit OUT_SYNC_CAP = 1'b1,
	parameter logic [15:0] WDOG_CYC = `IOFS_WDOG_CYC
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// process data from the bus
	input wire logic i_pd_valid,
	input wire logic [PD_W-1:0] i_pd_out,
	// parameter writes: sel 0 code, 1 sync enable, 2 sync point
	input wire iofs_pkg::iofs_param_wr_s i_param,
	input wire logic [PD_W-1:0] i_subst_wdata,
	input wire logic i_subst_wr,
	// sync strobe from the coupler, asynchronous pin
	input wire logic i_sync_pin,
	input wire logic [PD_W-1:0] i_switch_on_val,
	// outputs
	output logic [PD_W-1:0] o_out_value,
	output logic o_out_update,
	output logic [PD_W-1:0] o_out_failsafe_values,
	output logic [15:0] o_failsafe_behaviour_code,
	output logic o_param_error,
	output logic [1:0] o_capabilities,
	output iofs_pkg::iofs_timing_s o_timing,
	output logic [15:0] o_sync_point,
	output logic o_sync_active,
	output iofs_pkg::iofs_state_e o_state
);

	// ------------------------------------------------
	// parameter checking
	// ------------------------------------------------
	function automatic logic code_ok(input logic [15:0] c);
		code_ok = (c <= `IOFS_CODE_SUBST);
	endfunction

	logic [15:0] code_reg;
	logic sync_en_reg;
	logic [15:0] sync_point_reg;
	logic err_reg;
	logic [PD_W-1:0] subst_reg;

	wire wr_code = i_param.wr && (i_param.sel == 2'h0);
	wire wr_sync = i_param.wr && (i_param.sel == 2'h1);
	wire wr_point = i_param.wr && (i_param.sel == 2'h2);
	wire wr_bad_sel = i_param.wr && (i_param.sel == 2'h3);
	wire code_bad = wr_code && !code_ok(i_param.data); // RQ1
	wire sync_bad = wr_sync && (i_param.data > 16'h0001);
	wire sync_unsup = wr_sync && i_param.data[0] && !OUT_SYNC_CAP
		&& !IN_SYNC_CAP;
	wire point_bad = wr_point && (i_param.data < `IOFS_LEAD_CYC);
	wire any_bad = code_bad || sync_bad || sync_unsup || point_bad
		|| wr_bad_sel; // RQ1

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			code_reg <= `IOFS_CODE_ZERO;
			sync_en_reg <= 1'b0;
			sync_point_reg <= `IOFS_LEAD_CYC;
			err_reg <= 1'b0;
			subst_reg <= '0;
		end else begin
			if (wr_code && !code_bad)
				code_reg <= i_param.data; // RQ11
			if (wr_sync && !sync_bad && !sync_unsup)
				sync_en_reg <= i_param.data[0]; // RQ7
			if (wr_point && !point_bad)
				sync_point_reg <= i_param.data; // RQ5
			if (i_param.wr)
				err_reg <= any_bad; // RQ1
			if (i_subst_wr)
				subst_reg <= i_subst_wdata; // RQ15
		end
	end

	// ------------------------------------------------
	// parameter write checks
	// ------------------------------------------------
	AST_GOOD_WR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_param.wr && !any_bad |=> !err_reg) // RQ1
		else $error("accepted write flagged");
	AST_POINT_KEPT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		point_bad |=> sync_point_reg == $past(sync_point_reg) && err_reg) // RQ1
		else $error("bad sync point not rejected");
	AST_SYNC_KEPT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		sync_bad || sync_unsup |=> sync_en_reg == $past(sync_en_reg)) // RQ7
		else $error("bad sync enable not rejected");

	// ------------------------------------------------
	// sync pin synchroniser and time point counter
	// ------------------------------------------------
	logic [2:0] sync_sr_reg;
	logic sync_lvl_reg;
	logic [15:0] tp_cnt_reg;
	logic tp_run_reg;

	wire sync_agree = (sync_sr_reg[1] == sync_sr_reg[2]);
	wire sync_rise = sync_agree && sync_sr_reg[2] && !sync_lvl_reg;
	wire tp_hit = tp_run_reg && (tp_cnt_reg == sync_point_reg);
	// only in sync mode is the instant scheduled; else data goes at once
	wire sync_mode = sync_en_reg && OUT_SYNC_CAP;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			sync_sr_reg <= 3'h0;
			sync_lvl_reg <= 1'b0;
			tp_cnt_reg <= 16'h0000;
			tp_run_reg <= 1'b0;
		end else begin
			sync_sr_reg <= {sync_sr_reg[1:0], i_sync_pin};
			if (sync_agree)
				sync_lvl_reg <= sync_sr_reg[2];
			if (sync_rise) begin
				tp_cnt_reg <= 16'h0000;
				tp_run_reg <= 1'b1;
			end else if (tp_hit) begin
				tp_run_reg <= 1'b0;
			end else if (tp_run_reg) begin
				tp_cnt_reg <= tp_cnt_reg + 16'h0001;
			end
		end
	end

	AST_TP_START: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		sync_rise |=> tp_run_reg && tp_cnt_reg == 16'h0000) // RQ3
		else $error("time point count not started");

	// ------------------------------------------------
	// process data capture and watchdog
	// ------------------------------------------------
	logic [PD_W-1:0] pd_hold_reg;
	logic pd_fresh_reg;
	logic [15:0] wdog_reg;
	iofs_pkg::iofs_state_e state_reg;
	iofs_pkg::iofs_state_e state_next;

	wire wdog_exp = (wdog_reg >= WDOG_CYC);
	// a pending word is applied at once or at the scheduled point
	wire apply = pd_fresh_reg && (!sync_mode || tp_hit); // RQ3 RQ6

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			iofs_pkg::IOFS_ST_SWITCH_ON:
				if (apply)
					state_next = iofs_pkg::IOFS_ST_RUN; // RQ8 RQ9
			iofs_pkg::IOFS_ST_RUN:
				// a word applied in this cycle goes out before failsafe; one still waiting for the sync point does not
				if (wdog_exp && !apply)
					state_next = iofs_pkg::IOFS_ST_FAILSAFE; // RQ10
			iofs_pkg::IOFS_ST_FAILSAFE:
				if (apply)
					state_next = iofs_pkg::IOFS_ST_RUN; // RQ16
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pd_hold_reg <= '0;
			pd_fresh_reg <= 1'b0;
			wdog_reg <= 16'h0000;
			state_reg <= iofs_pkg::IOFS_ST_SWITCH_ON;
		end else begin
			state_reg <= state_next;
			if (i_pd_valid) begin
				pd_hold_reg <= i_pd_out; // RQ3
				pd_fresh_reg <= 1'b1;
			end else if (apply) begin
				pd_fresh_reg <= 1'b0;
			end
			if (i_pd_valid)
				wdog_reg <= 16'h0000;
			else if (!wdog_exp)
				wdog_reg <= wdog_reg + 16'h0001;
		end
	end

	// ------------------------------------------------
	// output selection
	// ------------------------------------------------
	logic [PD_W-1:0] out_reg;
	logic upd_reg;
	logic [PD_W-1:0] fs_val;

	always_comb begin
		unique case (code_reg[1:0])
			2'h0: fs_val = '0; // RQ12
			2'h1: fs_val = '1; // RQ12
			2'h2: fs_val = out_reg; // RQ12
			2'h3: fs_val = subst_reg; // RQ13
		endcase
	end

	// entry waits one cycle behind a late apply, so state and value agree
	wire enter_fs = (state_reg == iofs_pkg::IOFS_ST_RUN) && wdog_exp
		&& !apply;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			out_reg <= '0;
			upd_reg <= 1'b0;
		end else begin
			upd_reg <= apply || enter_fs;
			if (apply)
				out_reg <= pd_hold_reg; // RQ16
			else if (enter_fs)
				out_reg <= fs_val; // RQ10
			else if (state_reg == iofs_pkg::IOFS_ST_SWITCH_ON)
				out_reg <= i_switch_on_val; // RQ8
		end
	end

	// ------------------------------------------------
	// reported figures
	// ------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_capabilities <= 2'h0;
			o_timing <= '0;
		end else begin
			o_capabilities[`IOFS_CAP_IN_SYNC_BIT] <= IN_SYNC_CAP; // RQ2
			o_capabilities[`IOFS_CAP_OUT_SYNC_BIT] <= OUT_SYNC_CAP;
			o_timing.min_repeat <= `IOFS_MIN_REPEAT_CYC; // RQ4
			// substitute mode needs an extra cycle to fetch its word
			o_timing.proc_time <= `IOFS_PROC_BASE_CYC
				+ {15'h0000, code_reg == `IOFS_CODE_SUBST};
			o_timing.lead_time <= `IOFS_LEAD_CYC;
		end
	end

	assign o_out_value = out_reg;
	assign o_out_update = upd_reg;
	assign o_out_failsafe_values = subst_reg;
	assign o_failsafe_behaviour_code = code_reg;
	assign o_param_error = err_reg;
	assign o_sync_point = sync_point_reg;
	assign o_sync_active = sync_en_reg;
	assign o_state = state_reg;

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	AST_CODE_KEPT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		code_bad |=> (code_reg == $past(code_reg)) && err_reg) // RQ1
		else $error("bad code not rejected");
	AST_FS_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		enter_fs && !apply && code_reg == `IOFS_CODE_ZERO
		|=> out_reg == '0 && state_reg == iofs_pkg::IOFS_ST_FAILSAFE) // RQ12
		else $error("zero failsafe wrong");
	AST_FS_SUBST: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		enter_fs && !apply && code_reg == `IOFS_CODE_SUBST
		|=> out_reg == $past(subst_reg)) // RQ13
		else $error("substitute failsafe wrong");
	AST_NO_EARLY_FS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_reg == iofs_pkg::IOFS_ST_SWITCH_ON && !apply
		|=> state_reg == iofs_pkg::IOFS_ST_SWITCH_ON) // RQ9
		else $error("failsafe armed too early");
	AST_ASYNC_FAST: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_pd_valid && !sync_mode ##1 !sync_mode |=> upd_reg) // RQ6
		else $error("async data not passed at once");
	AST_RESUME: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		apply |=> out_reg == $past(pd_hold_reg)
		&& state_reg == iofs_pkg::IOFS_ST_RUN) // RQ16
		else $error("no resume");
	AST_CAPS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!i_rst |=> o_capabilities == {OUT_SYNC_CAP, IN_SYNC_CAP}) // RQ2
		else $error("capabilities wrong");
	AST_SYNC_POINT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		sync_mode && pd_fresh_reg && !tp_hit |-> !apply) // RQ3
		else $error("update off sync point");
	AST_FS_FINAL: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		enter_fs && code_reg == `IOFS_CODE_FINAL |=> out_reg == '1) // RQ12
		else $error("final value failsafe wrong");
	AST_FS_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		enter_fs && code_reg == `IOFS_CODE_HOLD
		|=> out_reg == $past(out_reg)) // RQ12
		else $error("hold failsafe wrong");
	AST_FS_ENTER: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		enter_fs |=> state_reg == iofs_pkg::IOFS_ST_FAILSAFE && upd_reg) // RQ10
		else $error("failsafe entry incomplete");
	AST_FED_NO_FS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_pd_valid |=> !enter_fs) // RQ10
		else $error("failsafe while data arrives");
	// sampled reset keeps the attempt at the release edge vacuous
	AST_SWITCH_ON: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!i_rst && state_reg == iofs_pkg::IOFS_ST_SWITCH_ON && !apply
		|=> out_reg == $past(i_switch_on_val)) // RQ8
		else $error("switch-on value not driven");
endmodule

/* pkg/iofs_regs.svh */
`ifndef IOFS_REGS_SVH
`define IOFS_REGS_SVH

// failsafe behaviour codes
`define IOFS_CODE_ZERO 16'h0000
`define IOFS_CODE_FINAL 16'h0001
`define IOFS_CODE_HOLD 16'h0002
`define IOFS_CODE_SUBST 16'h0003
// capability object bits
`define IOFS_CAP_IN_SYNC_BIT 0
`define IOFS_CAP_OUT_SYNC_BIT 1
// timing figure defaults, in clock cycles
`define IOFS_MIN_REPEAT_CYC 16'h0032
`define IOFS_PROC_BASE_CYC 16'h000A
`define IOFS_LEAD_CYC 16'h0005
// process data watchdog, cycles without valid data before failsafe
`define IOFS_WDOG_CYC 16'h1388

`endif

/* pkg/iofs_pkg.sv */
package iofs_pkg;
	typedef enum logic [1:0] {
		IOFS_ST_SWITCH_ON,
		IOFS_ST_RUN,
		IOFS_ST_FAILSAFE
	} iofs_state_e;

	typedef struct packed {
		logic [15:0] min_repeat;
		logic [15:0] proc_time;
		logic [15:0] lead_time;
	} iofs_timing_s;

	typedef struct packed {
		logic wr;
		logic [1:0] sel;
		logic [15:0] data;
	} iofs_param_wr_s;
endpackage

/* testbench/iofs_coupler.sv */
`timescale 1ns/1ps
// ----------------------------------------
// coupler side of the local bus
// ----------------------------------------
module iofs_coupler (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// requests from the bench
	input wire logic i_send,
	input wire logic [15:0] i_word,
	input wire logic i_sync_go,
	// local bus side
	output logic o_pd_valid,
	output logic [15:0] o_pd_out,
	output logic o_sync_pin
);
	logic [1:0] sync_cnt_reg;
	// idle data lines flip to the inverse each cycle, so the stale word returns every second cycle
	always_ff @(posedge i_ref_clk) begin
		o_pd_valid <= i_send && !i_rst;
		o_pd_out <= i_send ? i_word : ~o_pd_out;
		if (i_rst) begin
			sync_cnt_reg <= 2'h0;
		end else begin
			sync_cnt_reg <= i_sync_go ? 2'h3 : sync_cnt_reg - {1'b0, |sync_cnt_reg};
		end
	end
	assign o_sync_pin = |sync_cnt_reg;
endmodule

/* testbench/iofs_ctrl_bench.sv */
`timescale 1ns/1ps
`include "iofs_regs.svh"
module iofs_ctrl_bench;
	localparam int WD = 40;
	logic clk = 1'b0;
	logic rst = 1'b1;
	iofs_pkg::iofs_param_wr_s prm = '0;
	logic [15:0] subst = 16'h0000;
	logic subst_wr = 1'b0;
	logic send = 1'b0;
	logic [15:0] word = 16'h0000;
	logic sync_go = 1'b0;
	logic [15:0] sw_on = 16'h5AC3;
	logic pd_valid, sync_pin, upd, perr, sact;
	logic [15:0] pd_out, outv, fsv, code, spt, w;
	logic [1:0] caps;
	iofs_pkg::iofs_timing_s tim;
	iofs_pkg::iofs_state_e st;
	logic [15:0] expq[$];
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	initial begin
		forever #10 clk = ~clk;
	end
	iofs_coupler cpl (.i_ref_clk(clk), .i_rst(rst), .i_send(send),
		.i_word(word), .i_sync_go(sync_go), .o_pd_valid(pd_valid),
		.o_pd_out(pd_out), .o_sync_pin(sync_pin));
	iofs_ctrl #(.PD_W(16), .WDOG_CYC(16'(WD))) dut (.i_ref_clk(clk),
		.i_rst(rst), .i_pd_valid(pd_valid), .i_pd_out(pd_out),
		.i_param(prm), .i_subst_wdata(subst), .i_subst_wr(subst_wr),
		.i_sync_pin(sync_pin), .i_switch_on_val(sw_on),
		.o_out_value(outv), .o_out_update(upd), .o_out_failsafe_values(fsv),
		.o_failsafe_behaviour_code(code), .o_param_error(perr),
		.o_capabilities(caps), .o_timing(tim), .o_sync_point(spt),
		.o_sync_active(sact), .o_state(st));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (fails == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wparam(input logic [1:0] sel, input logic [15:0] d,
		input logic err);
		@(posedge clk);
		prm <= '{1'b1, sel, d};
		@(posedge clk);
		prm.wr <= 1'b0;
		step(2);
		check(48'(perr), 48'(err));
	endtask
	// send stays high so calls in a row go back to back
	task automatic put(input logic [15:0] d);
		@(posedge clk);
		send <= 1'b1;
		word <= d;
		expq.push_back(d);
	endtask
	task automatic idle();
		@(posedge clk);
		send <= 1'b0;
	endtask
	// ----------------------------------------
	// output watcher
	// ----------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (!rst && upd === 1'b1) begin
			if (expq.size() == 0) begin
				fails++;
				$display("ERROR %0t: unexpected update", $time);
			end else begin
				check(48'(outv), 48'(expq.pop_front()));
			end
		end
		if (cyc == 2000) begin
			fails++;
			test_done();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h818B));
		step(8);
		rst <= 1'b0;
		step(3);
		check(48'(outv), 48'(sw_on));
		check(48'(caps), 48'h3);
		check(tim, {`IOFS_MIN_REPEAT_CYC, `IOFS_PROC_BASE_CYC, `IOFS_LEAD_CYC});
		wparam(2'h0, 16'h0004, 1'b1);
		wparam(2'h3, 16'h0001, 1'b1);
		wparam(2'h1, 16'h0002, 1'b1);
		wparam(2'h2, 16'h0004, 1'b1);
		check(48'({code, spt, sact}), 48'({16'h0, 16'h5, 1'b0}));
		wparam(2'h2, 16'h0007, 1'b0);
		check(48'(spt), 48'h7);
		@(posedge clk);
		subst <= 16'($urandom);
		subst_wr <= 1'b1;
		@(posedge clk);
		subst_wr <= 1'b0;
		step(2);
		check(48'(fsv), 48'(subst));
		step(WD + 10);
		check(48'({st, outv}), 48'({iofs_pkg::IOFS_ST_SWITCH_ON, sw_on}));
		for (int c = 0; c < 4; c++) begin
			wparam(2'h0, 16'(c), 1'b0);
			check(48'(code), 48'(c));
			w = 16'($urandom);
			put(16'($urandom));
			put(w);
			idle();
			step(3);
			check(48'(st), 48'(iofs_pkg::IOFS_ST_RUN));
			expq.push_back(c == 0 ? 16'h0 : c == 1 ? 16'hFFFF : c == 2 ? w : subst);
			step(WD + 8);
			check(48'(st), 48'(iofs_pkg::IOFS_ST_FAILSAFE));
		end
		check(tim, {`IOFS_MIN_REPEAT_CYC, `IOFS_PROC_BASE_CYC + 16'h0001, `IOFS_LEAD_CYC});
		wparam(2'h1, 16'h0001, 1'b0);
		wparam(2'h2, 16'h0005, 1'b0);
		check(48'(sact), 48'h1);
		put(16'($urandom));
		idle();
		step(6);
		check(48'(expq.size()), 48'h1);
		@(posedge clk);
		sync_go <= 1'b1;
		@(posedge clk);
		sync_go <= 1'b0;
		step(14);
		check(48'(expq.size()), 48'h0);
		expq.push_back(subst);
		step(WD + 8);
		wparam(2'h1, 16'h0000, 1'b0);
		put(16'($urandom));
		idle();
		step(6);
		check(48'({expq.size(), sact}), 48'h0);
		test_done();
	end
endmodule
